// *** bench/pos_rx_length_and_stats_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
    $display("MISMATCH t=%0t got %h expected %h", $time, got, exp); end end
module pos_rx_length_and_stats_tb
    import prxs_pkg::*;
;
    logic        clk_sys, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, eof_d, busy, go;
    logic        rx_sof, rx_info_byte, rx_byte_valid, rx_eof, rx_abort, rx_fcs_error, rx_overrun;
    logic        rx_frame_dropped, rx_mark_errored, rx_store_frame, abt, fcs, ovr, drp, gap;
    logic [9:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, m;
    logic [15:0] nb, rnd;
    logic [33:0] q_rd[$];
    logic [1:0]  q_b[$], q_mk[$];
    int          err_count, n_compared, n, mx;

    prxs_stats u_dut (.*);
    prxs_hdlc_model u_src (.*);

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic axw(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
        q_b.push_back(er);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic axr(input logic [7:0] idx, input logic [31:0] exp);
        q_rd.push_back({(idx == 8'h7F) ? PRXS_RESP_SLVERR : PRXS_RESP_OKAY, exp});
        s_axi_araddr <= {idx, 2'b00};
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Mark code: bit 1 asks for a check, bit 0 is the expected mark.
    task automatic frm(input int len, input logic a, f, o, d, g, input logic [1:0] mk);
        q_mk.push_back(mk);
        {nb, abt, fcs, ovr, drp, gap, go} <= {len[15:0], a, f, o, d, g, 1'b1};
        @(posedge clk_sys);
        go <= 1'b0;
        @(posedge clk_sys);
        while (busy) @(posedge clk_sys);
    endtask

    task automatic snap4(input logic [7:0] a, b, c, e);
        axw(a, '0, PRXS_RESP_OKAY);
        axw(b, '0, PRXS_RESP_OKAY);
        axw(c, '0, PRXS_RESP_OKAY);
        axw(e, '0, PRXS_RESP_OKAY);
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        eof_d <= rx_eof;
        if (eof_d)
        begin
            m = q_mk.pop_front();
            if (m[1]) `CHK(rx_mark_errored, m[0])
        end
        if (s_axi_rvalid && s_axi_rready) `CHK({s_axi_rresp, s_axi_rdata}, q_rd.pop_front())
        if (s_axi_bvalid && s_axi_bready) `CHK(s_axi_bresp, q_b.pop_front())
    end

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        final_report();
    end

    initial
    begin
        {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go, eof_d} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, nb, abt, fcs, ovr, drp, gap} = '0;
        s_axi_wstrb = 4'hf;
        rnd = 16'h09A0;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        axr(PRXS_IDX_MIN_PL, 32'h0000_0002);
        axr(PRXS_IDX_MAX_PL, 32'h0000_0600);
        axr(PRXS_IDX_FRM_LO, 32'h0000_0000);
        rnd = lfsr(rnd);
        n = 2 + int'(rnd[2:0]);
        frm(n, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'b10);
        frm(n, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 2'b11);
        frm(n, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'b11);
        frm(1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'b11);
        snap4(PRXS_IDX_FRM_HI, PRXS_IDX_BYTE_HI, PRXS_IDX_ABORT_HI, PRXS_IDX_FCS_HI);
        axr(PRXS_IDX_FRM_LO, 32'h0000_0001);
        axr(PRXS_IDX_FRM_HI, 32'h0000_0000);
        axr(PRXS_IDX_BYTE_LO, 32'(n));
        axr(PRXS_IDX_ABORT_LO, 32'h0000_0001);
        axr(PRXS_IDX_FCS_LO, 32'h0000_0001);
        rnd = lfsr(rnd);
        mx = 3 + int'(rnd[1:0]);
        axw(PRXS_IDX_MAX_PL, 32'(mx), PRXS_RESP_OKAY);
        axr(PRXS_IDX_MAX_PL, 32'(mx));
        axw(PRXS_IDX_CONFIG, 32'h0000_0004, PRXS_RESP_OKAY);
        frm(1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'b10);
        frm(mx + 1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'b10);
        axw(PRXS_IDX_CONFIG, 32'h0000_0006, PRXS_RESP_OKAY);
        frm(mx + 1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'b11);
        frm(n, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'b11);
        frm(n, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'b11);
        frm(0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 2'b00);
        snap4(PRXS_IDX_FRM_HI, PRXS_IDX_BYTE_HI, PRXS_IDX_ABORT_HI, PRXS_IDX_OVF);
        axr(PRXS_IDX_FRM_LO, 32'h0000_0002);
        axr(PRXS_IDX_BYTE_LO, 32'(3 + 2 * mx + 2 * n));
        axr(PRXS_IDX_ABORT_LO, 32'h0000_0001);
        axr(PRXS_IDX_OVF, 32'h0000_0002);
        axw(PRXS_IDX_FRM_HI, '0, PRXS_RESP_OKAY);
        axr(PRXS_IDX_FRM_LO, 32'h0000_0000);
        axw(8'h7F, '0, PRXS_RESP_SLVERR);
        axr(8'h7F, 32'h0000_0000);
        axw(PRXS_IDX_MIN_PL, {24'h00_0000, rnd[15:8]}, PRXS_RESP_OKAY);
        axr(PRXS_IDX_MIN_PL, {24'h00_0000, rnd[15:8]});
        repeat (3) @(posedge clk_sys);
        final_report();
    end
endmodule
`default_nettype wire

// *** bench/prxs_hdlc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module prxs_hdlc_model
(
    input  wire logic        clk_sys,
    input  wire logic        go,
    input  wire logic [15:0] nb,
    input  wire logic        abt,
    input  wire logic        fcs,
    input  wire logic        ovr,
    input  wire logic        drp,
    input  wire logic        gap,
    output logic             rx_sof,
    output logic             rx_info_byte,
    output logic             rx_byte_valid,
    output logic             rx_eof,
    output logic             rx_abort,
    output logic             rx_fcs_error,
    output logic             rx_overrun,
    output logic             rx_frame_dropped,
    output logic             busy
);
    initial
    begin
        {busy, rx_sof, rx_info_byte, rx_byte_valid, rx_eof} = '0;
        {rx_abort, rx_fcs_error, rx_overrun, rx_frame_dropped} = '0;
        forever
        begin
            @(posedge clk_sys);
            if (go)
            begin
                busy <= 1'b1;
                rx_sof <= 1'b1;
                rx_frame_dropped <= drp;
                @(posedge clk_sys);
                rx_sof <= 1'b0;
                rx_frame_dropped <= 1'b0;
                // A dropped frame never reaches the FIFO, so it carries no byte strobes.
                for (int i = 0; i < nb && !drp; i++)
                begin
                    rx_byte_valid <= 1'b1;
                    rx_info_byte <= 1'b1;
                    @(posedge clk_sys);
                    if (gap)
                    begin
                        rx_byte_valid <= 1'b0;
                        rx_info_byte <= 1'b0;
                        @(posedge clk_sys);
                    end
                end
                rx_byte_valid <= 1'b0;
                rx_info_byte <= 1'b0;
                {rx_eof, rx_abort, rx_fcs_error, rx_overrun} <= {1'b1, abt, fcs, ovr};
                @(posedge clk_sys);
                {rx_eof, rx_abort, rx_fcs_error, rx_overrun, busy} <= '0;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/prxs_stats_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module prxs_stats_sva
    import prxs_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [9:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        rx_sof,
    input wire logic        rx_eof,
    input wire logic        rx_abort,
    input wire logic        rx_fcs_error,
    input wire logic        rx_frame_dropped,
    input wire logic        rx_mark_errored,
    input wire logic        rx_store_frame
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    wr_resp_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write response late");
    rd_resp_time_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read response late");
    rd_data_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    min_width_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == PRXS_IDX_MIN_PL
        |-> ##[1:2] s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000) else $error("min length too wide");
    frm_hi_width_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == PRXS_IDX_FRM_HI
        |-> ##[1:2] s_axi_rvalid && s_axi_rdata[31:11] == 21'h00_0000) else $error("frame high word too wide");
    abort_mark_a: assert property (rx_eof && rx_abort |=> rx_mark_errored)
        else $error("aborted frame not marked");
    fcs_mark_a: assert property (rx_eof && rx_fcs_error |=> rx_mark_errored)
        else $error("bad check frame not marked");
    mark_cause_a: assert property (rx_mark_errored |-> $past(rx_eof))
        else $error("mark without frame end");
    mark_pulse_a: assert property (rx_mark_errored |=> !rx_mark_errored)
        else $error("mark longer than one cycle");
    drop_store_a: assert property (rx_sof && rx_frame_dropped |=> !rx_store_frame)
        else $error("dropped frame still stored");
    keep_store_a: assert property (rx_sof && !rx_frame_dropped |=> rx_store_frame)
        else $error("kept frame not stored");
endmodule
bind prxs_stats prxs_stats_sva u_sva (.*);
`default_nettype wire

// *** include/prxs_pkg.sv ***
`default_nettype none
package prxs_pkg;
    // Printed offsets are register indices; byte address is four times the index.
    localparam logic [7:0] PRXS_IDX_MIN_PL      = 8'h61;
    localparam logic [7:0] PRXS_IDX_MAX_PL      = 8'h62;
    localparam logic [7:0] PRXS_IDX_FRM_LO      = 8'h63;
    localparam logic [7:0] PRXS_IDX_FRM_HI      = 8'h64;
    localparam logic [7:0] PRXS_IDX_BYTE_LO     = 8'h65;
    localparam logic [7:0] PRXS_IDX_BYTE_HI     = 8'h66;
    localparam logic [7:0] PRXS_IDX_ABORT_LO    = 8'h67;
    localparam logic [7:0] PRXS_IDX_ABORT_HI    = 8'h68;
    localparam logic [7:0] PRXS_IDX_FCS_LO      = 8'h69;
    localparam logic [7:0] PRXS_IDX_FCS_HI      = 8'h6A;
    localparam logic [7:0] PRXS_IDX_OVF         = 8'h6B;
    localparam logic [7:0] PRXS_IDX_CONFIG      = 8'h70;
    localparam logic [7:0] PRXS_IDX_ROLLOVER    = 8'h71;

    localparam logic [7:0]  PRXS_MIN_PL_RST     = 8'h02;
    localparam logic [15:0] PRXS_MAX_PL_RST     = 16'h0600;
    localparam int          PRXS_FRM_W          = 27;
    localparam int          PRXS_BYTE_W         = 29;
    localparam int          PRXS_ABORT_W        = 20;
    localparam int          PRXS_FCS_W          = 20;
    localparam int          PRXS_OVF_W          = 16;

    // Configuration register bits.
    localparam int          PRXS_CFG_SHORT_BIT  = 0;
    localparam int          PRXS_CFG_LONG_BIT   = 1;
    localparam int          PRXS_CFG_ALLB_BIT   = 2;
    localparam logic [2:0]  PRXS_CFG_RST        = 3'h3;

    // Rollover flag positions.
    localparam int          PRXS_RO_FRM         = 0;
    localparam int          PRXS_RO_BYTE        = 1;
    localparam int          PRXS_RO_ABORT       = 2;
    localparam int          PRXS_RO_FCS         = 3;
    localparam int          PRXS_RO_OVF         = 4;

    localparam logic [1:0]  PRXS_RESP_OKAY      = 2'h0;
    localparam logic [1:0]  PRXS_RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0]
    {
        PRXS_FR_IDLE  = 2'b00,
        PRXS_FR_BUSY  = 2'b01,
        PRXS_FR_SKIP  = 2'b10
    } prxs_frame_state_t;
endpackage
`default_nettype wire

// *** rtl/prxs_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
module prxs_counter
    import prxs_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int STEPW = 1
)
(
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             inc,
    input  wire logic [STEPW-1:0] step,
    input  wire logic             snap,
    output logic      [WIDTH-1:0] held,
    output logic                  rollover
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH:0]   sum;

    assign sum      = {1'b0, count_r} + {{(WIDTH+1-STEPW){1'b0}}, step};
    assign rollover = inc && sum[WIDTH];

    // A snapshot taking the count in the same cycle as an event keeps that event for the next interval.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            count_r <= '0;  // [RULE8]
        else if (snap)
            count_r <= inc ? sum[WIDTH-1:0] - count_r : '0;  // [RULE7] [RULE8]
        else if (inc)
            count_r <= sum[WIDTH-1:0];  // [RULE21]
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            held <= '0;
        else if (snap)
            held <= count_r;  // [RULE7] [RULE21]
    end
endmodule
`default_nettype wire

// *** rtl/prxs_len_check.sv ***
`timescale 1ns/1ps
`default_nettype none
module prxs_len_check
    import prxs_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        start,
    input  wire logic        info_byte,
    input  wire logic [7:0]  min_len,
    input  wire logic [15:0] max_len,
    output logic             too_short,
    output logic             too_long
);
    logic [16:0] len_r;
    logic [16:0] len_now;

    // Start clears, so a byte in the start cycle counts for the new frame.
    assign len_now   = (start ? 17'h0_0000 : len_r) + {16'h0000, info_byte};
    assign too_short = len_r < {9'h000, min_len};  // [RULE2]
    assign too_long  = len_r > {1'b0, max_len};  // [RULE4]

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            len_r <= '0;
        else if (!len_r[16] || start)
            len_r <= len_now;
    end
endmodule
`default_nettype wire

// *** rtl/prxs_stats.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1 - Minimum length register, 8 bits, default two
// RULE2 - Optionally mark packets shorter than minimum
// RULE3 - Maximum length register, 16 bits, default 1536
// RULE4 - Optionally mark packets longer than maximum
// RULE5 - Count good unmarked frames, 27 bits
// RULE6 - Aborted frames never count as good
// RULE7 - Write snapshots counter into buffer, clears it
// RULE8 - Counters cover current interval, reset to zero
// RULE9 - Good count split at bit sixteen
// RULE10 - Count received bytes, 29 bits, split
// RULE11 - Option off: count only good-frame bytes
// RULE12 - Option on: count every stored byte
// RULE13 - Count aborted frames; stored and marked errored
// RULE14 - Aborted count split at bit sixteen
// RULE15 - Count FCS-errored frames; stored and marked
// RULE16 - Count frames lost to FIFO overrun
// RULE17 - Partial or dropped overrun frames both count
// RULE18 - Short packets always stored completely
// RULE19 - Short mark applied only when enabled
// RULE20 - Counter rollover sets flag, cleared by read
// RULE21 - Counters wrap; buffer waits for next snapshot
module prxs_stats
    import prxs_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [9:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [9:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rx_sof,
    input  wire logic        rx_info_byte,
    input  wire logic        rx_byte_valid,
    input  wire logic        rx_eof,
    input  wire logic        rx_abort,
    input  wire logic        rx_fcs_error,
    input  wire logic        rx_overrun,
    input  wire logic        rx_frame_dropped,
    output logic             rx_mark_errored,
    output logic             rx_store_frame
);
    logic [7:0]        min_len_r;
    logic [15:0]       max_len_r;
    logic [2:0]        cfg_r;
    logic [4:0]        ro_flags_r;
    prxs_frame_state_t fr_state_r;
    logic [9:0]        aw_addr_r;
    logic [31:0]       w_data_r;
    logic              aw_full_r;
    logic              w_full_r;
    logic [9:0]        ar_addr_r;
    logic              ar_full_r;
    logic [15:0]       frame_bytes_r;
    logic              frame_ovr_r;
    logic              too_short;
    logic              too_long;
    logic              len_err;
    logic              frame_bad;
    logic              wr_fire;
    logic              rd_fire;
    logic [7:0]        wr_idx;
    logic [7:0]        rd_idx;
    logic [PRXS_FRM_W-1:0]   frm_held;
    logic [PRXS_BYTE_W-1:0]  byte_held;
    logic [PRXS_ABORT_W-1:0] abort_held;
    logic [PRXS_FCS_W-1:0]   fcs_held;
    logic [PRXS_OVF_W-1:0]   ovf_held;
    logic [4:0]        ro_set;
    logic              end_good;
    logic              count_byte;
    logic [31:0]       rd_word;
    logic              rd_ok;

    function automatic logic [7:0] word_index(input logic [9:0] addr);
        word_index = addr[9:2];
    endfunction

    // Word write with byte lanes for the low sixteen bits.
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    assign wr_fire = aw_full_r && w_full_r && !s_axi_bvalid;
    assign rd_fire = ar_full_r && !s_axi_rvalid;
    assign wr_idx  = word_index(aw_addr_r);
    assign rd_idx  = word_index(ar_addr_r);

    prxs_len_check u_len
    (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .start     (rx_sof),
        .info_byte (rx_byte_valid && rx_info_byte),
        .min_len   (min_len_r),
        .max_len   (max_len_r),
        .too_short (too_short),
        .too_long  (too_long)
    );

    assign len_err   = (too_short && cfg_r[PRXS_CFG_SHORT_BIT])  // [RULE2] [RULE19]
                     || (too_long && cfg_r[PRXS_CFG_LONG_BIT]);  // [RULE4]
    assign frame_bad = rx_abort || rx_fcs_error || frame_ovr_r || rx_overrun || len_err;  // [RULE13] [RULE15]
    assign end_good  = rx_eof && fr_state_r == PRXS_FR_BUSY && !frame_bad;  // [RULE5] [RULE6]

    // Frame tracking: a dropped overrun frame stores nothing but is still counted.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            fr_state_r <= PRXS_FR_IDLE;
        else if (rx_sof)
            fr_state_r <= rx_frame_dropped ? PRXS_FR_SKIP : PRXS_FR_BUSY;  // [RULE17]
        else if (rx_eof)
            fr_state_r <= PRXS_FR_IDLE;
        else
        begin
            case (fr_state_r)
                PRXS_FR_IDLE: fr_state_r <= PRXS_FR_IDLE;
                PRXS_FR_BUSY: fr_state_r <= PRXS_FR_BUSY;
                PRXS_FR_SKIP: fr_state_r <= PRXS_FR_SKIP;
                default:      fr_state_r <= PRXS_FR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            frame_ovr_r <= 1'b0;
        else if (rx_sof)
            frame_ovr_r <= rx_overrun;
        else if (rx_overrun)
            frame_ovr_r <= 1'b1;  // [RULE17]
    end

    // Bytes of the open frame are held back until its verdict when only good bytes count.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            frame_bytes_r <= '0;
        else if (rx_sof || rx_eof)
            frame_bytes_r <= '0;
        else if (rx_byte_valid && frame_bytes_r != 16'hFFFF)
            frame_bytes_r <= frame_bytes_r + 16'h0001;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_mark_errored <= 1'b0;
            rx_store_frame  <= 1'b0;
        end
        else
        begin
            rx_mark_errored <= rx_eof && frame_bad;  // [RULE13] [RULE15] [RULE19]
            rx_store_frame  <= rx_sof ? !rx_frame_dropped : (rx_eof || fr_state_r != PRXS_FR_SKIP);  // [RULE18]
        end
    end

    assign count_byte = rx_byte_valid && fr_state_r != PRXS_FR_SKIP && cfg_r[PRXS_CFG_ALLB_BIT];  // [RULE12]

    prxs_counter #(.WIDTH(PRXS_FRM_W), .STEPW(1)) u_frm
    (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .inc      (end_good),  // [RULE5]
        .step     (1'b1),
        .snap     (wr_fire && wr_idx == PRXS_IDX_FRM_HI),  // [RULE7]
        .held     (frm_held),
        .rollover (ro_set[PRXS_RO_FRM])
    );

    prxs_counter #(.WIDTH(PRXS_BYTE_W), .STEPW(17)) u_byte
    (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .inc      (count_byte || (end_good && !cfg_r[PRXS_CFG_ALLB_BIT])),  // [RULE11] [RULE12]
        .step     (count_byte ? 17'h0_0001 : {1'b0, frame_bytes_r} + {16'h0000, rx_byte_valid}),  // [RULE11]
        .snap     (wr_fire && wr_idx == PRXS_IDX_BYTE_HI),
        .held     (byte_held),
        .rollover (ro_set[PRXS_RO_BYTE])
    );

    prxs_counter #(.WIDTH(PRXS_ABORT_W), .STEPW(1)) u_abort
    (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .inc      (rx_eof && rx_abort && fr_state_r == PRXS_FR_BUSY),  // [RULE13]
        .step     (1'b1),
        .snap     (wr_fire && wr_idx == PRXS_IDX_ABORT_HI),
        .held     (abort_held),
        .rollover (ro_set[PRXS_RO_ABORT])
    );

    prxs_counter #(.WIDTH(PRXS_FCS_W), .STEPW(1)) u_fcs
    (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .inc      (rx_eof && rx_fcs_error && !rx_abort && fr_state_r == PRXS_FR_BUSY),  // [RULE15]
        .step     (1'b1),
        .snap     (wr_fire && wr_idx == PRXS_IDX_FCS_HI),
        .held     (fcs_held),
        .rollover (ro_set[PRXS_RO_FCS])
    );

    prxs_counter #(.WIDTH(PRXS_OVF_W), .STEPW(1)) u_ovf
    (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .inc      (rx_eof && (frame_ovr_r || rx_overrun || fr_state_r == PRXS_FR_SKIP)),  // [RULE16] [RULE17]
        .step     (1'b1),
        .snap     (wr_fire && wr_idx == PRXS_IDX_OVF),
        .held     (ovf_held),
        .rollover (ro_set[PRXS_RO_OVF])
    );

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            min_len_r <= PRXS_MIN_PL_RST;  // [RULE1]
            max_len_r <= PRXS_MAX_PL_RST;  // [RULE3]
            cfg_r     <= PRXS_CFG_RST;
        end
        else if (wr_fire)
        begin
            if (wr_idx == PRXS_IDX_MIN_PL && s_axi_wstrb[0])
                min_len_r <= w_data_r[7:0];  // [RULE1]
            if (wr_idx == PRXS_IDX_MAX_PL)
                max_len_r <= merge16(max_len_r, w_data_r, s_axi_wstrb);  // [RULE3]
            if (wr_idx == PRXS_IDX_CONFIG)
                cfg_r <= w_data_r[2:0];
        end
    end

    // A rollover in the same cycle as the clearing read stays set.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            ro_flags_r <= '0;
        else if (rd_fire && rd_idx == PRXS_IDX_ROLLOVER)
            ro_flags_r <= ro_set;  // [RULE20]
        else
            ro_flags_r <= ro_flags_r | ro_set;  // [RULE20]
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (rd_idx)
            PRXS_IDX_MIN_PL:   rd_word = {24'h00_0000, min_len_r};
            PRXS_IDX_MAX_PL:   rd_word = {16'h0000, max_len_r};
            PRXS_IDX_FRM_LO:   rd_word = {16'h0000, frm_held[15:0]};  // [RULE9]
            PRXS_IDX_FRM_HI:   rd_word = {21'h00_0000, frm_held[26:16]};  // [RULE9]
            PRXS_IDX_BYTE_LO:  rd_word = {16'h0000, byte_held[15:0]};  // [RULE10]
            PRXS_IDX_BYTE_HI:  rd_word = {19'h0_0000, byte_held[28:16]};  // [RULE10]
            PRXS_IDX_ABORT_LO: rd_word = {16'h0000, abort_held[15:0]};  // [RULE14]
            PRXS_IDX_ABORT_HI: rd_word = {28'h000_0000, abort_held[19:16]};  // [RULE14]
            PRXS_IDX_FCS_LO:   rd_word = {16'h0000, fcs_held[15:0]};
            PRXS_IDX_FCS_HI:   rd_word = {28'h000_0000, fcs_held[19:16]};
            PRXS_IDX_OVF:      rd_word = {16'h0000, ovf_held};
            PRXS_IDX_CONFIG:   rd_word = {29'h0000_0000, cfg_r};
            PRXS_IDX_ROLLOVER: rd_word = {27'h000_0000, ro_flags_r};
            default:           rd_ok   = 1'b0;
        endcase
    end

    // Address and data are latched separately so the master may offer them in either order.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aw_full_r     <= 1'b0;
            w_full_r      <= 1'b0;
            aw_addr_r     <= '0;
            w_data_r      <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= PRXS_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_r     <= s_axi_awaddr;
                aw_full_r     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_r     <= s_axi_wdata;
                w_full_r     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= ((wr_idx >= PRXS_IDX_MIN_PL && wr_idx <= PRXS_IDX_OVF) || wr_idx == PRXS_IDX_CONFIG)
                                ? PRXS_RESP_OKAY : PRXS_RESP_SLVERR;
                aw_full_r    <= 1'b0;
                w_full_r     <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ar_full_r     <= 1'b0;
            ar_addr_r     <= '0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= PRXS_RESP_OKAY;
        end
        else
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                ar_addr_r     <= s_axi_araddr;
                ar_full_r     <= 1'b1;
                s_axi_arready <= 1'b0;
            end
            if (rd_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? PRXS_RESP_OKAY : PRXS_RESP_SLVERR;
                ar_full_r    <= 1'b0;
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire
